// ---- core/rxsem_event_mask.sv ----
// module: receive signalling event masking and duplicate message filter
`timescale 1ns/10ps
`default_nettype none
module rxsem_event_mask #(
	parameter int unsigned SIG_WIDTH = rxsem_pkg::SIG_WIDTH_DEF
) (
	// clock and reset
	input  wire logic                             clock,
	input  wire logic                             rst,
	// channel configuration
	input  wire logic                             ss7_fcs16_mode,
	input  wire logic [rxsem_pkg::MASK_WIDTH-1:0] mask_bits,
	// monitor count changes, one-cycle pulses
	input  wire logic                             err_count_up_event,
	input  wire logic                             err_count_down_event,
	// line state events, one-cycle pulses
	input  wire logic                             abort_code_change_event,
	input  wire logic                             idle_code_change_event,
	input  wire logic                             short_msg_event,
	// end of received message with its signature
	input  wire logic                             msg_end,
	input  wire logic [SIG_WIDTH-1:0]             msg_signature,
	// detections, unmasked
	output logic                                  duplicate_msg_event,
	output logic                                  msg_discard,
	// interrupt requests after masking
	output logic                                  err_count_up_irq,
	output logic                                  err_count_down_irq,
	output logic                                  duplicate_msg_irq,
	output logic                                  line_state_irq
);
	import rxsem_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [SIG_WIDTH-1:0] last_sig_reg;
	logic [SIG_WIDTH-1:0] last_sig_next;
	logic                 have_last_reg;
	logic                 have_last_next;
	logic [EVT_COUNT-1:0] irq_reg;
	wire [EVT_COUNT-1:0]  irq_next;
	logic                 dup_reg;
	logic                 dup_next;
	wire                  err_count_up_mask   = mask_bits[MASK_COUNT_UP_BIT];
	wire                  err_count_down_mask = mask_bits[MASK_COUNT_DOWN_BIT];
	wire                  duplicate_msg_mask  = mask_bits[MASK_DUPLICATE_BIT];
	wire                  line_state_mask     = mask_bits[MASK_LINE_STATE_BIT];
	wire                  line_evt;
	wire                  dup_hit;
	wire [EVT_COUNT-1:0]  evt_raw;
	wire [EVT_COUNT-1:0]  evt_mask;

	////////////////////////////////////////////////////////////////////////
	// compare with previous
	assign dup_hit        = ss7_fcs16_mode && msg_end && have_last_reg && (msg_signature == last_sig_reg);
	assign last_sig_next  = msg_end ? msg_signature : last_sig_reg;
	assign have_last_next = (msg_end && ss7_fcs16_mode) ? 1'b1 : (ss7_fcs16_mode ? have_last_reg : 1'b0);
	assign dup_next       = dup_hit;
	assign line_evt       = abort_code_change_event || idle_code_change_event || short_msg_event;
	assign evt_raw[3]     = ss7_fcs16_mode && err_count_up_event;
	assign evt_raw[2]     = ss7_fcs16_mode && err_count_down_event;
	assign evt_raw[1]     = dup_hit;
	assign evt_raw[0]     = line_evt;
	assign evt_mask       = {err_count_up_mask, err_count_down_mask, duplicate_msg_mask, line_state_mask};

	for (genvar i = 0; i < EVT_COUNT; i++) begin : g_report
		assign irq_next[i] = evt_raw[i] && !evt_mask[i];
		a_report_gate: assert property (@(posedge clock) disable iff (rst)
			irq_reg[i] |-> $past(evt_raw[i]) && !$past(evt_mask[i]))
			else $error("report without unmasked event");
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			last_sig_reg  <= '0;
			have_last_reg <= HISTORY_RESET;
		end else begin
			last_sig_reg  <= last_sig_next;
			have_last_reg <= have_last_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			dup_reg <= DETECT_RESET;
		end else begin
			dup_reg <= dup_next;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			irq_reg <= EVT_NONE;
		end else begin
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign err_count_up_irq    = irq_reg[3];
	assign err_count_down_irq  = irq_reg[2];
	assign duplicate_msg_irq   = irq_reg[1];
	assign line_state_irq      = irq_reg[0];
	assign duplicate_msg_event = dup_reg;
	assign msg_discard         = dup_reg;

	////////////////////////////////////////////////////////////////////////
	sequence s_pair_same;
		msg_end && ss7_fcs16_mode && have_last_reg && (msg_signature == last_sig_reg);
	endsequence

	// unmasked and masked events at one edge
	sequence s_pair_open;
		s_pair_same ##0 !duplicate_msg_mask;
	endsequence
	sequence s_pair_hidden;
		s_pair_same ##0 duplicate_msg_mask;
	endsequence
	sequence s_up_open;
		ss7_fcs16_mode && err_count_up_event && !err_count_up_mask;
	endsequence
	sequence s_down_open;
		ss7_fcs16_mode && err_count_down_event && !err_count_down_mask;
	endsequence
	sequence s_line_open;
		line_evt && !line_state_mask;
	endsequence
	sequence s_first_msg;
		msg_end && ss7_fcs16_mode && !have_last_reg;
	endsequence

	a_dup_discard: assert property (@(posedge clock) disable iff (rst)
		s_pair_same |=> msg_discard)
		else $error("duplicate message not discarded");
	a_dup_irq_on: assert property (@(posedge clock) disable iff (rst)
		s_pair_open |=> duplicate_msg_irq)
		else $error("duplicate interrupt missing");
	a_dup_irq_mask: assert property (@(posedge clock) disable iff (rst)
		duplicate_msg_irq |-> $past(!duplicate_msg_mask) && msg_discard)
		else $error("duplicate interrupt while masked");
	a_down_irq: assert property (@(posedge clock) disable iff (rst)
		s_down_open |=> err_count_down_irq)
		else $error("decrement interrupt missing");
	a_down_cause: assert property (@(posedge clock) disable iff (rst)
		err_count_down_irq |-> $past(err_count_down_event) && $past(ss7_fcs16_mode))
		else $error("decrement interrupt without event");
	a_down_mask: assert property (@(posedge clock) disable iff (rst)
		$past(err_count_down_mask) |-> !err_count_down_irq)
		else $error("decrement interrupt while masked");
	a_up_irq: assert property (@(posedge clock) disable iff (rst)
		s_up_open |=> err_count_up_irq)
		else $error("increment interrupt missing");
	a_up_cause: assert property (@(posedge clock) disable iff (rst)
		err_count_up_irq |-> $past(err_count_up_event) && $past(ss7_fcs16_mode))
		else $error("increment interrupt without event");
	a_up_mask: assert property (@(posedge clock) disable iff (rst)
		$past(err_count_up_mask) |-> !err_count_up_irq)
		else $error("increment interrupt while masked");
	a_count_mode: assert property (@(posedge clock) disable iff (rst)
		!ss7_fcs16_mode |=> !err_count_up_irq && !err_count_down_irq)
		else $error("count interrupt outside signalling mode");
	a_line_irq: assert property (@(posedge clock) disable iff (rst)
		s_line_open |=> line_state_irq)
		else $error("line state interrupt missing");
	a_line_cause: assert property (@(posedge clock) disable iff (rst)
		line_state_irq |-> $past(line_evt))
		else $error("line state interrupt without event");
	a_line_mask: assert property (@(posedge clock) disable iff (rst)
		$past(line_state_mask) |-> !line_state_irq)
		else $error("line state interrupt while masked");
	a_mask_detect: assert property (@(posedge clock) disable iff (rst)
		s_pair_hidden |=> duplicate_msg_event && !duplicate_msg_irq)
		else $error("masked duplicate not detected");
	a_dup_stands: assert property (@(posedge clock) disable iff (rst)
		!(msg_end && ss7_fcs16_mode && have_last_reg && (msg_signature == last_sig_reg)) |=> !msg_discard)
		else $error("discard without duplicate");
	a_discard_cause: assert property (@(posedge clock) disable iff (rst)
		msg_discard |-> $past(msg_end) && $past(ss7_fcs16_mode))
		else $error("discard without message end");
	a_first_clean: assert property (@(posedge clock) disable iff (rst)
		s_first_msg |=> !duplicate_msg_event)
		else $error("first message flagged duplicate");
	a_mode_clear: assert property (@(posedge clock) disable iff (rst)
		!ss7_fcs16_mode |=> !have_last_reg)
		else $error("history kept outside signalling mode");
endmodule : rxsem_event_mask
`default_nettype wire

// ---- core/rxsem_pkg.sv ----
// package: constants for the receive signalling event mask block
`default_nettype none
package rxsem_pkg;
	// mask bit positions within the channel mask byte
	localparam int unsigned MASK_LINE_STATE_BIT = 4;
	localparam int unsigned MASK_DUPLICATE_BIT  = 5;
	localparam int unsigned MASK_COUNT_DOWN_BIT = 6;
	localparam int unsigned MASK_COUNT_UP_BIT   = 7;
	localparam int unsigned MASK_WIDTH          = 8;
	// value after reset: every event masked
	localparam logic [7:0]  MASK_RESET          = 8'hF0;
	// message signature width default
	localparam int unsigned SIG_WIDTH_DEF       = 32;
	// number of interrupt request outputs
	localparam int unsigned EVT_COUNT           = 4;
	localparam logic [3:0]  EVT_NONE            = 4'h0;
	localparam logic        HISTORY_RESET       = 1'b0;
	localparam logic        DETECT_RESET        = 1'h0;
endpackage : rxsem_pkg
`default_nettype wire

// ---- testbench/rx_signal_unit_event_mask_test.sv ----
// bench: directed checks of the receive event mask block
`timescale 1ns/10ps
`default_nettype none
module rx_signal_unit_event_mask_test;
	import rxsem_pkg::*;
	logic             clock = 1'b0;
	logic             rst   = 1'b1;
	logic             mode  = 1'b0;
	logic             me    = 1'b0;
	logic [7:0]       mask  = MASK_RESET;
	logic [4:0]       ev    = 5'h00;
	logic [31:0]      sig   = 32'h0;
	wire logic [5:0]  got;
	int               bad_count  = 0;
	int               n_compared = 0;
	always #2 clock = ~clock;
	rxsem_event_mask DUT (.clock(clock), .rst(rst), .ss7_fcs16_mode(mode), .mask_bits(mask),
		.err_count_up_event(ev[4]), .err_count_down_event(ev[3]), .abort_code_change_event(ev[2]),
		.idle_code_change_event(ev[1]), .short_msg_event(ev[0]), .msg_end(me), .msg_signature(sig),
		.duplicate_msg_event(got[5]), .msg_discard(got[4]), .err_count_up_irq(got[3]),
		.err_count_down_irq(got[2]), .duplicate_msg_irq(got[1]), .line_state_irq(got[0]));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [5:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask : chk
	// drive one cycle, judge outputs after its sampling edge
	task automatic cyc(input string what, input logic [7:0] m, input logic [4:0] e, input logic x,
		input logic [31:0] s, input logic [5:0] exp);
		mask = m;
		ev = e;
		me = x;
		sig = s;
		@(negedge clock);
		chk(what, exp);
	endtask : cyc
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	task automatic t_count;
		mode = 1'b1;
		cyc("up", 8'h00, 5'h10, 1'h0, 32'h0, 6'h08);
		cyc("down", 8'h00, 5'h08, 1'h0, 32'h0, 6'h04);
		cyc("up masked", 8'h80, 5'h18, 1'h0, 32'h0, 6'h04);
		cyc("down masked", 8'h40, 5'h18, 1'h0, 32'h0, 6'h08);
		mode = 1'b0;
		cyc("mode off", 8'h00, 5'h18, 1'h0, 32'h0, 6'h00);
		$display("test count done");
	endtask : t_count
	task automatic t_line;
		cyc("abort", 8'h00, 5'h04, 1'h0, 32'h0, 6'h01);
		cyc("idle", 8'h00, 5'h02, 1'h0, 32'h0, 6'h01);
		cyc("short", 8'h00, 5'h01, 1'h0, 32'h0, 6'h01);
		cyc("all", 8'h00, 5'h07, 1'h0, 32'h0, 6'h01);
		cyc("line masked", 8'h10, 5'h07, 1'h0, 32'h0, 6'h00);
		$display("test line done");
	endtask : t_line
	task automatic t_dup;
		mode = 1'b1;
		cyc("first", 8'h00, 5'h00, 1'h1, 32'hA5A50001, 6'h00);
		cyc("second", 8'h00, 5'h00, 1'h1, 32'hA5A50001, 6'h32);
		cyc("third", 8'h00, 5'h00, 1'h1, 32'hA5A50001, 6'h32);
		cyc("new", 8'h00, 5'h00, 1'h1, 32'hA5A50002, 6'h00);
		cyc("dup masked", 8'h20, 5'h00, 1'h1, 32'hA5A50002, 6'h30);
		mode = 1'b0;
		cyc("dup mode off", 8'h00, 5'h00, 1'h1, 32'hA5A50002, 6'h00);
		mode = 1'b1;
		cyc("after clear", 8'h00, 5'h00, 1'h1, 32'hA5A50002, 6'h00);
		cyc("quiet", 8'h00, 5'h00, 1'h0, 32'h0, 6'h00);
		$display("test duplicate done");
	endtask : t_dup
	task automatic t_reset;
		mode = 1'b1;
		cyc("arm", 8'h00, 5'h00, 1'h1, 32'h5A5A0003, 6'h00);
		rst = 1'b1;
		cyc("in reset", 8'h00, 5'h1F, 1'h1, 32'h5A5A0003, 6'h00);
		rst = 1'b0;
		cyc("after reset", 8'h00, 5'h00, 1'h1, 32'h5A5A0003, 6'h00);
		$display("test reset done");
	endtask : t_reset
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(negedge clock);
		rst = 1'b0;
		chk("reset", 6'h00);
		t_count;
		t_line;
		t_dup;
		t_reset;
		close_out;
	end
endmodule : rx_signal_unit_event_mask_test
`default_nettype wire
